// ==== design/buck_pg_pin_router.v ====
// Routes the buck power-good events onto the multipurpose pins behind a Wishbone register slave.
`timescale 1ns/1ps
`include "pg_route_defines.vh"

module buck_pg_pin_router #(
  parameter NUM_PINS = 7
) (
  // Clock and reset.
  input  wire                CORE_CLK,
  input  wire                SRST,
  // Wishbone slave.
  input  wire                WB_CYC_I,
  input  wire                WB_STB_I,
  input  wire                WB_WE_I,
  input  wire [9:0]          WB_ADR_I,
  input  wire [3:0]          WB_SEL_I,
  input  wire [31:0]         WB_DAT_I,
  output reg  [31:0]         WB_DAT_O,
  output reg                 WB_ACK_O,
  // Power-good levels of the three regulators.
  input  wire                BUCK1_POWER_GOOD,
  input  wire                BUCK2_POWER_GOOD,
  input  wire                BUCK3_POWER_GOOD,
  // Multipurpose pin interrupt drive and system interrupt.
  output reg  [NUM_PINS-1:0] MULTIPURPOSE_PIN_IRQ,
  output wire                IRQ
);

  reg  [2:0]          pg_last;
  reg  [2:0]          pg_event;
  reg  [NUM_PINS-1:0] route [0:2];
  reg  [2:0]          irq_status;
  reg  [2:0]          irq_mask;
  reg                 pg_seeded;
  wire [2:0]          pg_now = {BUCK3_POWER_GOOD, BUCK2_POWER_GOOD, BUCK1_POWER_GOOD};
  wire [2:0]          pg_change = pg_seeded ? (pg_now ^ pg_last) : 3'h0;
  wire [7:0]          word_idx = WB_ADR_I[9:2];
  wire                req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire                wr_lane0 = req & WB_WE_I & WB_SEL_I[0];
  // Buck1 is wired to the low three pins only; buck3 to the top two.
  wire [NUM_PINS-1:0] allowed [0:2];
  reg  [NUM_PINS-1:0] next_pins;
  integer             b;

  assign allowed[0] = 7'h07;
  assign allowed[1] = 7'h7F;
  assign allowed[2] = 7'h60;

  // Decodes which buck routing register a word index names, or 3 for none.
  function [1:0] route_sel;
    input [7:0] idx;
    begin
      case (idx)
        `PG_IDX_BUCK1_ROUTE: route_sel = 2'h0;
        `PG_IDX_BUCK2_ROUTE: route_sel = 2'h1;
        `PG_IDX_BUCK3_ROUTE: route_sel = 2'h2;
        default:             route_sel = 2'h3;
      endcase
    end
  endfunction

  wire [1:0] wr_route = route_sel(word_idx);

  // Event bits latch any power-good edge; a change seen while the bit is cleared wins.
  always @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      pg_last    <= 3'h0;
      pg_seeded  <= 1'b0;
      pg_event   <= 3'h0;
      irq_status <= 3'h0;
      irq_mask   <= `PG_MASK_RESET;
    end
    else
    begin
      pg_last   <= pg_now;
      pg_seeded <= 1'b1;
      // Reading a routing register clears its event bit, as software acknowledges it there.
      if (req & ~WB_WE_I & (wr_route != 2'h3))
        pg_event <= (pg_event & ~(3'h1 << wr_route)) | pg_change;
      else
        pg_event <= pg_event | pg_change;
      if (wr_lane0 & (word_idx == `PG_IDX_IRQ_STATUS))
        irq_status <= (irq_status & ~WB_DAT_I[2:0]) | pg_change;
      else
        irq_status <= irq_status | pg_change;
      if (wr_lane0 & (word_idx == `PG_IDX_IRQ_MASK))
        irq_mask <= WB_DAT_I[2:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_route
      // Unwired select bits are held at zero so they can never reach a pin.
      always @(posedge CORE_CLK)
      begin
        if (SRST)
          route[g] <= `PG_SEL_RESET;
        else if (wr_lane0 & (wr_route == g))
          route[g] <= WB_DAT_I[`PG_SEL_MSB:0] & allowed[g];
      end
    end
  endgenerate

  // Every selected pin carries the event, so one event may fan out to several pins.
  always @*
  begin
    next_pins = {NUM_PINS{1'b0}};
    for (b = 0; b < 3; b = b + 1)
      if (pg_event[b])
        next_pins = next_pins | route[b];
  end

  always @(posedge CORE_CLK)
  begin
    if (SRST)
      MULTIPURPOSE_PIN_IRQ <= {NUM_PINS{1'b0}};
    else
      MULTIPURPOSE_PIN_IRQ <= next_pins;
  end

  assign IRQ = |(irq_status & irq_mask);

  // Single-wait-state slave: ack one cycle after the strobe, then dropped.
  always @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= req;
      WB_DAT_O <= 32'h0000_0000;
      if (req & ~WB_WE_I)
      begin
        case (word_idx)
          `PG_IDX_PIN_STS:
            WB_DAT_O[2:0] <= {|route[2] & pg_event[2], |route[1] & pg_event[1], |route[0] & pg_event[0]};
          `PG_IDX_BUCK1_ROUTE: WB_DAT_O[7:0] <= {pg_event[0], route[0]};
          `PG_IDX_BUCK2_ROUTE: WB_DAT_O[7:0] <= {pg_event[1], route[1]};
          `PG_IDX_BUCK3_ROUTE: WB_DAT_O[7:0] <= {pg_event[2], route[2]};
          `PG_IDX_IRQ_STATUS:  WB_DAT_O[2:0] <= irq_status;
          `PG_IDX_IRQ_MASK:    WB_DAT_O[2:0] <= irq_mask;
          default:             WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // buck_pg_pin_router

// ==== design/pg_route_defines.vh ====
// Register map, field positions and reset values of the power-good pin interrupt router.
// Function
// - Buck2 event bit 7, read-only, flags change.
// - Buck3 event bit 7, read-only, flags change.
// - Buck2 select bit n drives pin n.
// - Buck2 select zero keeps pin clear.
// - Buck3 select bits 6,5 route pins.
// - Buck3 select zero keeps pin clear.
// - Buck1 select bits 2..0 route pins.
// - Buck1 select zero keeps pin clear.
// - Pin status bit 1 shows buck2 active.
`ifndef PG_ROUTE_DEFINES_VH
`define PG_ROUTE_DEFINES_VH

`define PG_IDX_PIN_STS      8'h6F
`define PG_IDX_BUCK1_ROUTE  8'h70
`define PG_IDX_BUCK2_ROUTE  8'h71
`define PG_IDX_BUCK3_ROUTE  8'h72
`define PG_IDX_IRQ_STATUS   8'h78
`define PG_IDX_IRQ_MASK     8'h79

`define PG_EVENT_BIT        7
`define PG_SEL_MSB          6
`define PG_STS_BUCK1        0
`define PG_STS_BUCK2        1
`define PG_STS_BUCK3        2

`define PG_SEL_RESET        7'h00
`define PG_MASK_RESET       3'h0

`endif

// ==== tb/pg_route_assertions.sv ====
// Port checker for the power-good pin router.
`timescale 1ns/1ps
module pg_route_assertions #(
  parameter NUM_PINS = 7
) (
  input wire                CORE_CLK, SRST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O,
  input wire [9:0]          WB_ADR_I,
  input wire [31:0]         WB_DAT_O,
  input wire                BUCK1_POWER_GOOD, BUCK2_POWER_GOOD, BUCK3_POWER_GOOD,
  input wire [NUM_PINS-1:0] MULTIPURPOSE_PIN_IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  wire rd = WB_ACK_O && !WB_WE_I;
  wire [7:0] ix = WB_ADR_I[9:2];
  wire [2:0] pg = {BUCK3_POWER_GOOD, BUCK2_POWER_GOOD, BUCK1_POWER_GOOD};
  wire [NUM_PINS-1:0] p = MULTIPURPOSE_PIN_IRQ;
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_pulse: assert property (p_pulse) else $error("long ack");
  property p_idle; !WB_ACK_O |-> WB_DAT_O == 0; endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_b1; rd && ix == 8'h70 |-> WB_DAT_O[6:3] == 0; endproperty
  a_b1: assert property (p_b1) else $error("buck1 bits");
  property p_b3; rd && ix == 8'h72 |-> WB_DAT_O[4:0] == 0; endproperty
  a_b3: assert property (p_b3) else $error("buck3 bits");
  property p_sts; rd && ix == 8'h6F |-> WB_DAT_O[31:3] == 0; endproperty
  a_sts: assert property (p_sts) else $error("status bits");
  property p_rise; |(p & ~$past(p)) |-> $past(WB_ACK_O && WB_WE_I) || $past(pg, 2) != $past(pg, 3); endproperty
  a_rise: assert property (p_rise) else $error("pin rose");
  property p_fall; |($past(p) & ~p) |-> $past(WB_ACK_O); endproperty
  a_fall: assert property (p_fall) else $error("pin fell");
endmodule // pg_route_assertions
bind buck_pg_pin_router pg_route_assertions #(.NUM_PINS(NUM_PINS)) chk_u (.*);

// ==== tb/pg_host_model.sv ====
// Host that records which multipurpose pins it has seen asserted.
`timescale 1ns/1ps
module pg_host_model (
  input wire       clk,
  input wire       clr,
  input wire [6:0] pins,
  output reg [6:0] seen
);
  always @(posedge clk) seen <= clr ? 7'h00 : seen | pins;
endmodule // pg_host_model

// ==== tb/buck_pg_pin_router_tb.sv ====
// Bench for the power-good pin router.
`timescale 1ns/1ps
module buck_pg_pin_router_tb;
  reg clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, clr = 1;
  reg [9:0] adr = 0;
  reg [31:0] wd = 0;
  reg [2:0] pg = 0;
  reg [3:0] sel = 0, lane = 4'h1;
  reg [7:0] rv;
  wire [31:0] rd;
  wire ack, irq;
  wire [6:0] pins, seen;
  int fail_count = 0, tests_run = 0;
  buck_pg_pin_router dut_u (.CORE_CLK(clk), .SRST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .BUCK1_POWER_GOOD(pg[0]),
    .BUCK2_POWER_GOOD(pg[1]), .BUCK3_POWER_GOOD(pg[2]), .MULTIPURPOSE_PIN_IRQ(pins), .IRQ(irq));
  pg_host_model host_u (.clk(clk), .clr(clr), .pins(pins), .seen(seen));
  initial forever #5 clk = ~clk;
  task stop_test;
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, a);
    tests_run++;
    if (a !== e) begin fail_count++; $display("ERROR %s exp %h got %h", nm, e, a); end
  endtask
  task bus(input logic w, input logic [7:0] ix, d);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; sel <= lane; adr <= {ix, 2'b00}; wd <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rv = rd[7:0];
    cyc <= 0; stb <= 0; we <= 0; sel <= 4'h0;
  endtask
  task rdc(input logic [7:0] ix, e);
    bus(0, ix, 8'h00);
    chk("rdata", e, rv);
  endtask
  // Pins are sampled three edges after the change, once the registered event has reached them.
  task tog(input int i);
    pg[i] <= ~pg[i];
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0; clr <= 0;
    rdc(8'h71, 8'h00);
    bus(1, 8'h71, 8'hFF); rdc(8'h71, 8'h7F);
    lane = 4'h0; bus(1, 8'h71, 8'h00); lane = 4'h1; rdc(8'h71, 8'h7F);
    bus(1, 8'h72, 8'hFF); rdc(8'h72, 8'h60);
    bus(1, 8'h70, 8'hFF); rdc(8'h70, 8'h07);
    tog(1); chk("pins", 8'h7F, {1'b0, pins});
    rdc(8'h6F, 8'h02);
    chk("seen", 8'h7F, {1'b0, seen});
    chk("irq", 8'h00, {7'h0, irq});
    bus(1, 8'h79, 8'h02); chk("irq", 8'h01, {7'h0, irq});
    rdc(8'h71, 8'hFF);
    bus(1, 8'h78, 8'h02); chk("irq", 8'h00, {7'h0, irq});
    chk("pins", 8'h00, {1'b0, pins});
    tog(2); chk("pins", 8'h60, {1'b0, pins});
    bus(1, 8'h72, 8'h20); bus(1, 8'h7A, 8'hFF); chk("pins", 8'h20, {1'b0, pins});
    tog(0); chk("pins", 8'h27, {1'b0, pins});
    bus(1, 8'h70, 8'h00); rdc(8'h70, 8'h80);
    chk("pins", 8'h20, {1'b0, pins});
    rdc(8'h72, 8'hA0);
    rdc(8'h7A, 8'h00);
    stop_test;
  end
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    stop_test;
  end
endmodule // buck_pg_pin_router_tb
